// File: hdl/iopmc_pkg.sv
// Package of offsets, masks and reset values for the port mode block.
// Assumes an 8-bit host data bus and an 8-bit register offset.
package iopmc_pkg;
    localparam int NPORT = 4;
    localparam logic [1:0] PORT_A = 2'h0;
    localparam logic [1:0] PORT_B = 2'h1;
    localparam logic [1:0] PORT_C = 2'h2;
    localparam logic [1:0] PORT_D = 2'h3;
    // Register bases in io_register_space, port index in bits 1:0
    localparam logic [7:0] OFS_DATA_IN = 8'h00;
    localparam logic [7:0] OFS_DATA_OUT = 8'h04;
    localparam logic [7:0] OFS_MODE = 8'h08;
    localparam logic [7:0] OFS_DIR = 8'h0c;
    localparam logic [7:0] OFS_DRIVE = 8'h10;
    localparam logic [7:0] OFS_ENABLE = 8'h14;
    localparam logic [7:0] OFS_IMC = 8'h18;
    localparam logic [7:0] OFS_PMR = 8'h1c;
    localparam logic [7:0] RST_CFG = 8'h00;
    localparam int PMR_PERIPH_BIT = 7;
    typedef logic [NPORT-1:0][7:0] iopmc_bytes_t;
    // Per-port capability masks, port D in the top byte
    localparam iopmc_bytes_t PIN_MASK = {8'h07, 8'hff, 8'hff, 8'hff};
    localparam iopmc_bytes_t MODE_MASK = {8'h00, 8'h00, 8'hff, 8'hff};
    localparam iopmc_bytes_t OD_MASK = {8'h00, 8'hff, 8'hf0, 8'hf0};
    localparam iopmc_bytes_t SLEW_MASK = {8'h07, 8'h00, 8'h0f, 8'h0f};
endpackage

// File: hdl/iopmc_pin_drv.sv
// Registered pin driver for one port: source select, enable, drive kind.
// Assumes all inputs are already on clk.
`timescale 1ns/1ps
`default_nettype none
module iopmc_pin_drv import iopmc_pkg::*; #(
    parameter int PORT = 0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Configuration
    input wire logic [7:0] mode,
    input wire logic [7:0] dir,
    input wire logic [7:0] drive,
    input wire logic [7:0] dout,
    input wire logic [7:0] addr,
    input wire logic [7:0] logic_oe,
    // Override by bus or programming functions
    input wire logic ovr_en,
    input wire logic [7:0] ovr_oe,
    input wire logic [7:0] ovr_out,
    // Pin side
    output logic [7:0] pin_out_ff,
    output logic [7:0] pin_oe_ff,
    output logic [7:0] slew_ff,
    output logic [7:0] en_ff
);
    logic [7:0] nxt_en, nxt_src, od;

    always_comb begin
        nxt_en = (dir | logic_oe) & PIN_MASK[PORT];
        nxt_src = (mode & MODE_MASK[PORT] & addr) |
                  (~(mode & MODE_MASK[PORT]) & dout);
        od = drive & OD_MASK[PORT];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_out_ff <= 8'h00;
            pin_oe_ff <= 8'h00;
            en_ff <= 8'h00;
            slew_ff <= 8'h00;
        end else begin
            slew_ff <= drive & SLEW_MASK[PORT];
            if (ovr_en) begin
                pin_out_ff <= ovr_out;
                pin_oe_ff <= ovr_oe;
                en_ff <= ovr_oe;
            end else begin
                // Open drain only ever pulls low
                pin_out_ff <= nxt_src & ~od;
                pin_oe_ff <= nxt_en & ~(od & nxt_src);
                en_ff <= nxt_en;
            end
        end
    end

    // ------------------------------
    // Checks
    // ------------------------------
    oe_or_dir_a: assert property (@(posedge clk) disable iff (!rst_n)
        !ovr_en |=> en_ff == $past((dir | logic_oe) & PIN_MASK[PORT]))
        else $error("enable is not dir or logic term");
    open_drain_a: assert property (@(posedge clk) disable iff (!rst_n)
        !ovr_en && (od & nxt_src) != 8'h00 |=>
        (pin_oe_ff & $past(od & nxt_src)) == 8'h00)
        else $error("open drain pin drove high");
    slew_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 slew_ff == $past(drive & SLEW_MASK[PORT]))
        else $error("slew select wrong");
    addr_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        !ovr_en && (mode & MODE_MASK[PORT]) == 8'hff && od == 8'h00
        |=> pin_out_ff == $past(addr))
        else $error("address out not driven");
endmodule // iopmc_pin_drv
`default_nettype wire

// File: hdl/iopmc_top.sv
// Port mode and configuration logic for four general ports.
// Assumes host bus and pins are asynchronous; logic terms are on clk.
`timescale 1ns/1ps
`default_nettype none
module iopmc_top import iopmc_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Host bus pins
    input wire logic host_cs_n,
    input wire logic host_wr_n,
    input wire logic host_rd_n,
    input wire logic host_address_strobe,
    input wire logic [7:0] host_addr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata_ff,
    output logic host_rdata_oe_ff,
    // Fixed configuration and logic array terms
    input wire logic bus_muxed,
    input wire logic data_port_mode,
    input wire logic peripheral_select_term_a,
    input wire logic peripheral_select_term_b,
    input wire logic [7:0] logic_oe_a,
    input wire logic [7:0] logic_oe_b,
    input wire logic [7:0] logic_oe_c,
    input wire logic [2:0] logic_oe_d,
    input wire logic [7:0] addr_in_sel_a,
    input wire logic [7:0] addr_in_sel_b,
    input wire logic [7:0] addr_in_sel_c,
    input wire logic [2:0] addr_in_sel_d,
    // In-system programming on port C
    input wire logic jtag_enable,
    input wire logic [7:0] jtag_pin_out,
    input wire logic [7:0] jtag_pin_oe,
    // Port A
    input wire logic [7:0] port_a_in,
    output logic [7:0] port_a_out,
    output logic [7:0] port_a_oe,
    output logic [7:0] port_a_slew_fast,
    // Port B
    input wire logic [7:0] port_b_in,
    output logic [7:0] port_b_out,
    output logic [7:0] port_b_oe,
    output logic [7:0] port_b_slew_fast,
    // Port C
    input wire logic [7:0] port_c_in,
    output logic [7:0] port_c_out,
    output logic [7:0] port_c_oe,
    // Port D
    input wire logic [2:0] port_d_in,
    output logic [2:0] port_d_out,
    output logic [2:0] port_d_oe,
    output logic [2:0] port_d_slew_fast,
    // Decode logic inputs
    output logic [7:0] decode_in_a_ff,
    output logic [7:0] decode_in_b_ff,
    output logic [7:0] decode_in_c_ff,
    output logic [2:0] decode_in_d_ff
);
    // ------------------------------
    // Pin synchronisers
    // ------------------------------
    localparam int SW = 47;
    logic [SW-1:0] s1_ff, s2_ff;
    logic cs_n_s, wr_n_s, rd_n_s, strobe_s, wr_d_ff, strobe_d_ff;
    logic [7:0] addr_s, wdata_s;
    iopmc_bytes_t pin_s;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // Bus idle levels, so no false strobe edge follows reset
            s1_ff <= {4'he, {(SW-4){1'b1}}};
            s2_ff <= {4'he, {(SW-4){1'b1}}};
        end else begin
            s1_ff <= {host_cs_n, host_wr_n, host_rd_n, host_address_strobe,
                      host_addr, host_wdata, port_a_in, port_b_in,
                      port_c_in, port_d_in};
            s2_ff <= s1_ff;
        end
    end

    assign {cs_n_s, wr_n_s, rd_n_s, strobe_s, addr_s, wdata_s} = s2_ff[46:27];
    assign pin_s = {5'h00, s2_ff[2:0], s2_ff[10:3], s2_ff[18:11],
                    s2_ff[26:19]};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_d_ff <= 1'b1;
            strobe_d_ff <= 1'b0;
        end else begin
            wr_d_ff <= wr_n_s;
            strobe_d_ff <= strobe_s;
        end
    end

    // ------------------------------
    // Host cycle decode
    // ------------------------------
    logic wr_fire, rd_act, psel, periph, periph_rd, periph_wr, strobe_fall;
    logic [7:0] wd, reg_mux;
    logic [1:0] ridx;
    iopmc_bytes_t mode_ff, dir_ff, drv_ff, dout_ff, imc_ff, en_w;
    logic [7:0] pmr_ff, alat_ff;

    assign wr_fire = !cs_n_s && wr_d_ff && !wr_n_s;
    assign rd_act = !cs_n_s && !rd_n_s;
    // Data port takes host data from port A pins
    assign wd = data_port_mode ? pin_s[PORT_A] : wdata_s;
    assign psel = peripheral_select_term_a || peripheral_select_term_b;
    assign periph = pmr_ff[PMR_PERIPH_BIT];
    assign periph_rd = periph && psel && cs_n_s && !rd_n_s;
    assign periph_wr = periph && psel && cs_n_s && !wr_n_s;
    assign strobe_fall = strobe_d_ff && !strobe_s;
    assign ridx = addr_s[1:0];

    function automatic logic hit(input logic [7:0] base, input int p);
        hit = wr_fire && addr_s == (base | {6'h00, 2'(p)});
    endfunction

    // ------------------------------
    // Configuration registers
    // ------------------------------
    for (genvar p = 0; p < NPORT; p++) begin : g_reg
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                mode_ff[p] <= RST_CFG;
                dir_ff[p] <= RST_CFG;
                drv_ff[p] <= RST_CFG;
                dout_ff[p] <= RST_CFG;
            end else begin
                // Each bit lands on the same pin index
                if (hit(OFS_MODE, p))
                    mode_ff[p] <= wd & MODE_MASK[p];
                if (hit(OFS_DIR, p))
                    dir_ff[p] <= wd;
                if (hit(OFS_DRIVE, p))
                    drv_ff[p] <= wd;
                if (hit(OFS_DATA_OUT, p))
                    dout_ff[p] <= wd;
            end
        end

        always_ff @(posedge clk) begin
            if (!rst_n)
                imc_ff[p] <= 8'h00;
            else if (strobe_fall)
                imc_ff[p] <= pin_s[p];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pmr_ff <= RST_CFG;
            alat_ff <= 8'h00;
        end else begin
            if (hit(OFS_PMR, 0))
                pmr_ff <= wd;
            if (strobe_fall)
                alat_ff <= addr_s;
        end
    end

    // ------------------------------
    // Read path
    // ------------------------------
    always_comb begin
        case ({addr_s[7:2], 2'b00})
            OFS_DATA_IN: reg_mux = pin_s[ridx];
            OFS_DATA_OUT: reg_mux = dout_ff[ridx];
            OFS_MODE: reg_mux = mode_ff[ridx];
            OFS_DIR: reg_mux = dir_ff[ridx];
            OFS_DRIVE: reg_mux = drv_ff[ridx];
            OFS_ENABLE: reg_mux = en_w[ridx];
            OFS_IMC: reg_mux = imc_ff[ridx];
            OFS_PMR: reg_mux = (ridx == 2'h0) ? pmr_ff : 8'h00;
            default: reg_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            host_rdata_ff <= 8'h00;
            host_rdata_oe_ff <= 1'b0;
        end else begin
            // Peripheral reads pass port A to the host
            host_rdata_ff <= periph_rd ? pin_s[PORT_A] : reg_mux;
            host_rdata_oe_ff <= (rd_act && !data_port_mode) || periph_rd;
        end
    end

    // ------------------------------
    // Pin drivers
    // ------------------------------
    iopmc_bytes_t loe, aout, ovr_oe, ovr_out, po, poe, slew, asel;
    logic [NPORT-1:0] ovr_en;

    assign loe = {5'h00, logic_oe_d, logic_oe_c, logic_oe_b, logic_oe_a};
    assign asel = {5'h00, addr_in_sel_d, addr_in_sel_c, addr_in_sel_b,
                   addr_in_sel_a};
    // Port A carries the latched address only on a multiplexed bus
    assign aout = {8'h00, 8'h00, alat_ff,
                   bus_muxed ? alat_ff : 8'h00};
    assign ovr_en = {1'b0, jtag_enable, 1'b0,
                     data_port_mode || periph};
    assign ovr_oe[PORT_A] = data_port_mode ? {8{rd_act}}
                                           : {8{periph_wr}};
    assign ovr_out[PORT_A] = data_port_mode ? host_rdata_ff : wdata_s;
    assign ovr_oe[PORT_B] = 8'h00;
    assign ovr_out[PORT_B] = 8'h00;
    assign ovr_oe[PORT_C] = jtag_pin_oe;
    assign ovr_out[PORT_C] = jtag_pin_out;
    assign ovr_oe[PORT_D] = 8'h00;
    assign ovr_out[PORT_D] = 8'h00;

    for (genvar p = 0; p < NPORT; p++) begin : g_pin
        iopmc_pin_drv #(.PORT(p)) u_drv (
            .clk(clk),
            .rst_n(rst_n),
            .mode(mode_ff[p]),
            .dir(dir_ff[p]),
            .drive(drv_ff[p]),
            .dout(dout_ff[p]),
            .addr(aout[p]),
            .logic_oe(loe[p]),
            .ovr_en(ovr_en[p]),
            .ovr_oe(ovr_oe[p]),
            .ovr_out(ovr_out[p]),
            .pin_out_ff(po[p]),
            .pin_oe_ff(poe[p]),
            .slew_ff(slew[p]),
            .en_ff(en_w[p])
        );
    end

    assign port_a_out = po[PORT_A];
    assign port_a_oe = poe[PORT_A];
    assign port_a_slew_fast = slew[PORT_A];
    assign port_b_out = po[PORT_B];
    assign port_b_oe = poe[PORT_B];
    assign port_b_slew_fast = slew[PORT_B];
    assign port_c_out = po[PORT_C];
    assign port_c_oe = poe[PORT_C];
    assign port_d_out = po[PORT_D][2:0];
    assign port_d_oe = poe[PORT_D][2:0];
    assign port_d_slew_fast = slew[PORT_D][2:0];

    // ------------------------------
    // Decode inputs
    // ------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            decode_in_a_ff <= 8'h00;
            decode_in_b_ff <= 8'h00;
            decode_in_c_ff <= 8'h00;
            decode_in_d_ff <= 3'h0;
        end else begin
            // Address inputs come from the strobe latch
            decode_in_a_ff <= (asel[0] & imc_ff[0]) |
                              (~asel[0] & pin_s[0]);
            decode_in_b_ff <= (asel[1] & imc_ff[1]) | (~asel[1] & pin_s[1]);
            decode_in_c_ff <= (asel[2] & imc_ff[2]) | (~asel[2] & pin_s[2]);
            decode_in_d_ff <= (asel[3][2:0] & imc_ff[3][2:0]) |
                              (~asel[3][2:0] & pin_s[3][2:0]);
        end
    end

    // ------------------------------
    // Checks
    // ------------------------------
    sequence strobe_fall_s;
        strobe_s ##1 !strobe_s;
    endsequence
    sequence dir_b_write_s;
        wr_fire && addr_s == (OFS_DIR | 8'h01);
    endsequence

    cfg_reset_a: assert property (@(posedge clk)
        !rst_n |=> mode_ff == '0 && dir_ff == '0 && drv_ff == '0)
        else $error("config not cleared by reset");
    dir_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        dir_b_write_s |=> dir_ff[1] == $past(wd))
        else $error("direction write lost");
    read_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
        !wr_fire |=> $stable(dir_ff) && $stable(drv_ff))
        else $error("register changed without write");
    mode_ports_a: assert property (@(posedge clk) disable iff (!rst_n)
        mode_ff[2] == 8'h00 && mode_ff[3] == 8'h00)
        else $error("mode bits on port C or D");
    addr_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
        strobe_fall_s |=> imc_ff[0] == $past(pin_s[0]))
        else $error("input latch missed strobe");
    periph_tri_a: assert property (@(posedge clk) disable iff (!rst_n)
        periph && !data_port_mode && !psel |=> port_a_oe == 8'h00)
        else $error("peripheral buffer not tri-stated");
    jtag_share_a: assert property (@(posedge clk) disable iff (!rst_n)
        jtag_enable |=> port_c_oe == $past(jtag_pin_oe))
        else $error("port C not given to programming");
    port_d_pins_a: assert property (@(posedge clk) disable iff (!rst_n)
        en_w[3][7:3] == 5'h00)
        else $error("port D upper enable set");
endmodule // iopmc_top
`default_nettype wire

// File: testbench/iopmc_host_model.sv
// Host microcontroller model: register bus cycles and address strobe.
// Assumes tasks are called just after a rising clk edge, after reset.
`timescale 1ns/1ps
`default_nettype none
module iopmc_host_model (
    // Clock
    input wire logic clk,
    // Host bus
    output logic host_cs_n,
    output logic host_wr_n,
    output logic host_rd_n,
    output logic host_address_strobe,
    output logic [7:0] host_addr,
    output logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata_ff
);
    initial begin
        host_cs_n = 1'b1;
        host_wr_n = 1'b1;
        host_rd_n = 1'b1;
        host_address_strobe = 1'b0;
        host_addr = 8'h00;
        host_wdata = 8'h00;
    end
    // --------------------------------------------------------------
    // Bus cycles
    // --------------------------------------------------------------
    // No pull-ups: released lines show the inverse of the last value
    task automatic release_bus();
        host_cs_n <= 1'b1;
        host_wr_n <= 1'b1;
        host_rd_n <= 1'b1;
        host_addr <= ~host_addr;
        host_wdata <= ~host_wdata;
        repeat (4) @(posedge clk);
    endtask
    // Strobe held 5 clk so the synchronised edge is seen
    task automatic wr(input logic sel, input logic [7:0] a,
                      input logic [7:0] d);
        host_cs_n <= ~sel;
        host_wr_n <= 1'b0;
        host_addr <= a;
        host_wdata <= d;
        repeat (5) @(posedge clk);
        release_bus();
    endtask
    task automatic rd(input logic sel, input logic [7:0] a,
                      output logic [7:0] d);
        host_cs_n <= ~sel;
        host_rd_n <= 1'b0;
        host_addr <= a;
        repeat (5) @(posedge clk);
        d = host_rdata_ff;
        release_bus();
    endtask
    task automatic latch(input logic [7:0] a);
        host_addr <= a;
        host_address_strobe <= 1'b1;
        repeat (4) @(posedge clk);
        host_address_strobe <= 1'b0;
        repeat (4) @(posedge clk);
        host_addr <= ~a;
        repeat (4) @(posedge clk);
    endtask
endmodule // iopmc_host_model
`default_nettype wire

// File: testbench/io_port_mode_config_tb_top.sv
// Testbench for the port mode block, one task per scenario.
// Assumes the host model in its own file and the design package.
`timescale 1ns/1ps
`default_nettype none
module io_port_mode_config_tb_top import iopmc_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic host_cs_n, host_wr_n, host_rd_n, host_address_strobe;
    logic host_rdata_oe_ff;
    logic [7:0] host_addr, host_wdata, host_rdata_ff;
    logic bus_muxed = 1'b0, data_port_mode = 1'b0, jtag_enable = 1'b0;
    logic peripheral_select_term_a = 1'b0, peripheral_select_term_b = 1'b0;
    logic [7:0] logic_oe_a = 8'h00, logic_oe_b = 8'h00, logic_oe_c = 8'h00;
    logic [2:0] logic_oe_d = 3'h0, addr_in_sel_d = 3'h0, port_d_in = 3'h0;
    logic [7:0] addr_in_sel_a = 8'h00, addr_in_sel_b = 8'h00;
    logic [7:0] addr_in_sel_c = 8'h00, jtag_pin_out = 8'h00;
    logic [7:0] jtag_pin_oe = 8'h00, port_a_in = 8'h00;
    logic [7:0] port_b_in = 8'h00, port_c_in = 8'h00;
    logic [7:0] port_a_out, port_a_oe, port_a_slew_fast, port_b_out;
    logic [7:0] port_b_oe, port_b_slew_fast, port_c_out, port_c_oe;
    logic [2:0] port_d_out, port_d_oe, port_d_slew_fast, decode_in_d_ff;
    logic [7:0] decode_in_a_ff, decode_in_b_ff, decode_in_c_ff;
    int errors = 0;
    int checks_done = 0;
    always #4 clk = ~clk;
    iopmc_top iopmc_top_inst (
        .clk, .rst_n, .host_cs_n, .host_wr_n, .host_rd_n,
        .host_address_strobe, .host_addr, .host_wdata, .host_rdata_ff,
        .host_rdata_oe_ff, .bus_muxed, .data_port_mode,
        .peripheral_select_term_a, .peripheral_select_term_b,
        .logic_oe_a, .logic_oe_b, .logic_oe_c, .logic_oe_d,
        .addr_in_sel_a, .addr_in_sel_b, .addr_in_sel_c, .addr_in_sel_d,
        .jtag_enable, .jtag_pin_out, .jtag_pin_oe,
        .port_a_in, .port_a_out, .port_a_oe, .port_a_slew_fast,
        .port_b_in, .port_b_out, .port_b_oe, .port_b_slew_fast,
        .port_c_in, .port_c_out, .port_c_oe,
        .port_d_in, .port_d_out, .port_d_oe, .port_d_slew_fast,
        .decode_in_a_ff, .decode_in_b_ff, .decode_in_c_ff, .decode_in_d_ff
    );
    iopmc_host_model iopmc_host_model_inst (
        .clk, .host_cs_n, .host_wr_n, .host_rd_n, .host_address_strobe,
        .host_addr, .host_wdata, .host_rdata_ff
    );
    // --------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        iopmc_host_model_inst.wr(1'b1, a, d);
    endtask
    task automatic rchk(input string what, input logic [7:0] a,
                        input logic [7:0] exp);
        logic [7:0] d;
        iopmc_host_model_inst.rd(1'b1, a, d);
        check(what, exp, d);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic test_regs();
        int p;
        check("a oe rst", 8'h00, port_a_oe);
        for (p = 0; p < 4; p++) begin
            rchk("dir rst", OFS_DIR | p[7:0], RST_CFG);
            rchk("drive rst", OFS_DRIVE | p[7:0], RST_CFG);
            rchk("mode rst", OFS_MODE | p[7:0], RST_CFG);
            wreg(OFS_DIR | p[7:0], 8'h5a + p[7:0]);
            wreg(OFS_DRIVE | p[7:0], 8'ha0 + p[7:0]);
        end
        for (p = 0; p < 4; p++) begin
            rchk("dir rw", OFS_DIR | p[7:0], 8'h5a + p[7:0]);
            rchk("drive rw", OFS_DRIVE | p[7:0], 8'ha0 + p[7:0]);
            wreg(OFS_DIR | p[7:0], 8'h00);
            wreg(OFS_DRIVE | p[7:0], 8'h00);
        end
        wreg(OFS_MODE | 8'h02, 8'hff);
        rchk("mode c", OFS_MODE | 8'h02, 8'h00);
        wreg(OFS_MODE | 8'h01, 8'h3c);
        rchk("mode b", OFS_MODE | 8'h01, 8'h3c);
        rchk("mode b again", OFS_MODE | 8'h01, 8'h3c);
        wreg(OFS_MODE | 8'h01, 8'h00);
        wreg(8'h20, 8'hff);
        rchk("unmapped", 8'h20, 8'h00);
        $display("test regs done");
    endtask
    task automatic test_dir();
        wreg(OFS_DATA_OUT, 8'ha5);
        wreg(OFS_DIR, 8'h07);
        check("a oe dir", 8'h07, port_a_oe);
        check("a out", 8'h05, port_a_out & port_a_oe);
        logic_oe_a <= 8'h30;
        logic_oe_d <= 3'h4;
        tick(3);
        check("a oe or", 8'h37, port_a_oe);
        check("d oe term", 8'h04, {5'h0, port_d_oe});
        rchk("a enable", OFS_ENABLE, 8'h37);
        wreg(OFS_DATA_OUT | 8'h03, 8'hfd);
        wreg(OFS_DIR | 8'h03, 8'hff);
        check("d oe", 8'h07, {5'h0, port_d_oe});
        check("d out", 8'h05, {5'h0, port_d_out});
        rchk("d enable", OFS_ENABLE | 8'h03, 8'h07);
        logic_oe_a <= 8'h00;
        logic_oe_d <= 3'h0;
        wreg(OFS_DIR | 8'h03, 8'h00);
        wreg(OFS_DIR, 8'h00);
        check("a oe off", 8'h00, port_a_oe);
        $display("test dir done");
    endtask
    task automatic test_drive();
        wreg(OFS_DIR, 8'hff);
        wreg(OFS_DRIVE, 8'hff);
        check("a slew", 8'h0f, port_a_slew_fast);
        check("b slew", 8'h00, port_b_slew_fast);
        check("a oe od", 8'h5f, port_a_oe);
        check("a out od", 8'h05, port_a_out);
        wreg(OFS_DATA_OUT | 8'h02, 8'h0f);
        wreg(OFS_DIR | 8'h02, 8'hff);
        wreg(OFS_DRIVE | 8'h02, 8'hff);
        check("c oe od", 8'hf0, port_c_oe);
        wreg(OFS_DRIVE | 8'h03, 8'hff);
        check("d slew", 8'h07, {5'h0, port_d_slew_fast});
        wreg(OFS_DIR, 8'h00);
        wreg(OFS_DIR | 8'h02, 8'h00);
        // Open drain on port A would mask the address out test
        wreg(OFS_DRIVE, 8'h00);
        $display("test drive done");
    endtask
    task automatic test_addr_out();
        wreg(OFS_DATA_OUT | 8'h01, 8'h81);
        wreg(OFS_MODE | 8'h01, 8'hff);
        iopmc_host_model_inst.latch(8'h3c);
        check("b mode only", 8'h00, port_b_oe);
        wreg(OFS_DIR | 8'h01, 8'hff);
        check("b addr out", 8'h3c, port_b_out);
        wreg(OFS_DIR | 8'h01, 8'h00);
        logic_oe_b <= 8'hff;
        bus_muxed <= 1'b1;
        wreg(OFS_MODE, 8'hff);
        wreg(OFS_DIR, 8'hff);
        iopmc_host_model_inst.latch(8'hc3);
        check("a addr out", 8'hc3, port_a_out);
        check("b addr term", 8'hc3, port_b_out & port_b_oe);
        wreg(OFS_MODE | 8'h01, 8'h00);
        check("b host io", 8'h81, port_b_out);
        bus_muxed <= 1'b0;
        logic_oe_b <= 8'h00;
        wreg(OFS_MODE, 8'h00);
        wreg(OFS_DIR, 8'h00);
        $display("test address out done");
    endtask
    task automatic test_imc();
        port_c_in <= 8'h5a;
        port_a_in <= 8'h96;
        port_d_in <= 3'h5;
        port_b_in <= 8'h3c;
        addr_in_sel_a <= 8'hff;
        addr_in_sel_b <= 8'hff;
        addr_in_sel_c <= 8'hff;
        addr_in_sel_d <= 3'h7;
        tick(4);
        iopmc_host_model_inst.latch(8'h00);
        port_c_in <= 8'h11;
        port_a_in <= 8'h00;
        port_d_in <= 3'h0;
        tick(4);
        rchk("c imc", OFS_IMC | 8'h02, 8'h5a);
        check("c decode", 8'h5a, decode_in_c_ff);
        check("a decode", 8'h96, decode_in_a_ff);
        check("b decode", 8'h3c, decode_in_b_ff);
        check("d decode", 8'h05, {5'h0, decode_in_d_ff});
        addr_in_sel_c <= 8'h00;
        tick(4);
        check("c decode live", 8'h11, decode_in_c_ff);
        $display("test input latch done");
    endtask
    task automatic test_data_port();
        wreg(OFS_DIR | 8'h01, 8'h69);
        wreg(OFS_DIR, 8'hff);
        data_port_mode <= 1'b1;
        tick(3);
        check("a idle", 8'h00, port_a_oe);
        fork
            rchk("b dir", OFS_DIR | 8'h01, 8'h69);
            begin
                tick(5);
                check("a drives", 8'hff, port_a_oe);
                check("a data", 8'h69, port_a_out);
                // Read data leave through port A instead
                check("rdata oe", 8'h00, {7'h0, host_rdata_oe_ff});
            end
        join
        data_port_mode <= 1'b0;
        wreg(OFS_DIR, 8'h00);
        wreg(OFS_DIR | 8'h01, 8'h00);
        $display("test data port done");
    endtask
    task automatic test_periph();
        int i;
        logic [7:0] exp;
        wreg(OFS_PMR, 8'h80);
        rchk("mapping", OFS_PMR, 8'h80);
        for (i = 0; i < 4; i++) begin
            peripheral_select_term_a <= i[0];
            peripheral_select_term_b <= i[1];
            tick(3);
            fork
                iopmc_host_model_inst.wr(1'b0, 8'h00, 8'h96);
                begin
                    tick(5);
                    exp = (i == 0) ? 8'h00 : 8'hff;
                    check("periph oe", exp, port_a_oe);
                    check("periph out", 8'h96 & exp, port_a_out & exp);
                end
            join
        end
        port_a_in <= 8'h3c;
        fork
            iopmc_host_model_inst.rd(1'b0, 8'h00, exp);
            begin
                tick(5);
                check("periph rd oe", 8'h01, {7'h0, host_rdata_oe_ff});
            end
        join
        check("periph rd", 8'h3c, exp);
        peripheral_select_term_a <= 1'b0;
        peripheral_select_term_b <= 1'b0;
        wreg(OFS_PMR, 8'h00);
        $display("test peripheral done");
    endtask
    task automatic test_jtag();
        jtag_enable <= 1'b1;
        jtag_pin_out <= 8'ha5;
        jtag_pin_oe <= 8'h3c;
        tick(3);
        check("c jtag out", 8'ha5, port_c_out);
        check("c jtag oe", 8'h3c, port_c_oe);
        jtag_enable <= 1'b0;
        tick(3);
        check("c io again", 8'h00, port_c_oe);
        $display("test jtag done");
    endtask
    // --------------------------------------------------------------
    // Sequence
    // --------------------------------------------------------------
    initial begin
        tick(16);
        rst_n <= 1'b1;
        tick(4);
        test_regs();
        test_dir();
        test_drive();
        test_addr_out();
        test_imc();
        test_data_port();
        test_periph();
        test_jtag();
        complete_run();
    end
    // Hang guard, well above the whole sequence
    initial begin
        tick(40000);
        errors++;
        $display("mismatch watchdog expected 0 seen 1");
        complete_run();
    end
endmodule // io_port_mode_config_tb_top
`default_nettype wire
